// ==== tw_assertions.sv ====
module tw_assertions #(
  parameter int PROG_CYCLES = 200
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // pins
  input wire logic i_scl_clk,
  input wire logic i_write_protect,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  // status
  input wire logic o_standby,
  input wire logic o_prog_busy,
  input wire logic o_sn_sel,
  input wire logic o_read_op,
  input wire logic o_dev_ack,
  input wire logic o_wr_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  int busy_cnt;
  // cycles spent in the program cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !o_prog_busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_drive_low_only: assert property (o_sda_o == 1'b0)
    else $error("sda output not low");
  a_reset_standby: assert property (disable iff (1'b0)
    $fell(i_srst) |-> o_sda_oe && o_standby && !o_prog_busy) else $error("bad reset state");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl_clk)
    else $error("sda moved with scl high");
  a_ack_one_cycle: assert property (o_dev_ack |=> !o_dev_ack)
    else $error("ack pulse too long");
  a_busy_no_ack: assert property (o_dev_ack |-> !o_prog_busy)
    else $error("ack while busy");
  a_busy_not_standby: assert property (o_prog_busy |-> !o_standby)
    else $error("standby while busy");
  a_busy_min_run: assert property ($rose(o_prog_busy) |-> o_prog_busy [*8])
    else $error("program cycle too short");
  a_prog_bound: assert property (o_prog_busy |-> busy_cnt < PROG_CYCLES)
    else $error("program cycle too long");
  a_wp_no_write: assert property (o_wr_valid |-> !i_write_protect)
    else $error("write under protect");
  a_sn_no_write: assert property (o_wr_valid |-> !o_sn_sel && !o_read_op)
    else $error("write to read-only place");
  a_standby_released: assert property (o_standby |-> o_sda_oe)
    else $error("sda pulled in standby");
  c_prog: cover property ($rose(o_prog_busy));
  c_sn_ack: cover property (o_dev_ack && o_sn_sel);
  c_rd_ack: cover property (o_dev_ack && o_read_op);
  c_sn_rd: cover property (o_dev_ack && o_sn_sel && o_read_op);
endmodule : tw_assertions

// ==== tw_ctrl_model.sv ====
module tw_ctrl_model (
  // wire level
  input wire logic i_sda_wire,
  // driven lines
  output logic o_scl,
  output logic o_sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  logic tick = 1'b0;
  initial o_scl = 1'b1;
  initial o_sda_drv = 1'b1;
  // link timebase, 32 ns, free phase
  initial begin
    #3;
    forever #16 tick = ~tick;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge tick);
  endtask : wt
  // data falls with scl high
  task automatic start_c();
    o_sda_drv = 1'b1;
    wt(1);
    o_scl = 1'b1;
    wt(3);
    o_sda_drv = 1'b0;
    wt(3);
    o_scl = 1'b0;
    wt(1);
  endtask : start_c
  // data rises with scl high, scl then stands high
  task automatic stop_c();
    o_sda_drv = 1'b0;
    wt(2);
    o_scl = 1'b1;
    wt(3);
    o_sda_drv = 1'b1;
    wt(3);
  endtask : stop_c
  // data set only while scl low
  task automatic bit_c(input logic b, output logic s);
    o_sda_drv = b;
    wt(2);
    o_scl = 1'b1;
    wt(2);
    s = i_sda_wire;
    wt(1);
    o_scl = 1'b0;
    wt(1);
  endtask : bit_c
  // msb first, ninth clock samples ack
  task automatic byte_c(input logic [7:0] w, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(w[i], s);
    bit_c(1'b1, s);
    ack = ~s;
  endtask : byte_c
  // nine released clocks for recovery
  task automatic clk9();
    logic s;
    repeat (9) bit_c(1'b1, s);
  endtask : clk9
endmodule : tw_ctrl_model

// ==== tw_link_if.sv ====
interface tw_link_if;
  logic bit_tgl;
  logic bit_val;
  logic prog_start;
  logic prog_busy;
  modport link (output bit_tgl, output bit_val);
  modport core (input bit_tgl, input bit_val, output prog_start, input prog_busy);
  modport timer (input prog_start, output prog_busy);
endinterface : tw_link_if

// ==== tw_link_rx.sv ====
module tw_link_rx (
  // link clock and reset
  input wire logic i_scl_clk,
  input wire logic i_srst,
  // data pin
  input wire logic i_sda_i,
  // to core
  tw_link_if.link lk
);
  logic tgl_reg;
  logic val_reg;

  // one toggle per serial clock rise, data held until the next rise
  always_ff @(posedge i_scl_clk or posedge i_srst) begin
    if (i_srst) begin
      tgl_reg <= 1'b0;
      val_reg <= 1'b0;
    end else begin
      tgl_reg <= ~tgl_reg;
      val_reg <= i_sda_i;
    end
  end

  assign lk.bit_tgl = tgl_reg;
  assign lk.bit_val = val_reg;
endmodule : tw_link_rx

// ==== tw_pkg.sv ====
package tw_pkg;
  // word and address widths
  localparam int WORD_W = 8;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 4;
  // bit counter marks
  localparam logic [3:0] BIT_WORD_DONE = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE = 4'h9;
  // device address word codes and fields
  localparam logic [3:0] DEV_CODE_ARRAY = 4'ha;
  localparam logic [3:0] DEV_CODE_SERIAL = 4'hb;
  localparam int DEV_CODE_MSB = 7;
  localparam int DEV_CODE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_DIR_BIT = 0;
  // first word-address byte fields
  localparam int WA1_HI_MSB = 3;
  localparam int WA1_HI_LSB = 0;
  localparam int SN_TAG_MSB = 3;
  localparam int SN_TAG_LSB = 2;
  localparam logic [1:0] SN_TAG = 2'h2;
  // second word-address byte fields
  localparam int WA2_LO_MSB = 7;
  localparam int SN_OFS_MSB = 4;
  localparam int SN_OFS_W = 5;
  // synchronised pin vector layout
  localparam int PIN_N = 6;
  localparam int PIN_SCL = 5;
  localparam int PIN_SDA = 4;
  localparam int PIN_WP = 3;
  localparam int PIN_SEL_MSB = 2;
  localparam int PIN_SEL_LSB = 0;
  // reset values
  localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  // program cycle timing
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int SYS_CLK_KHZ = 125000;
  localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * SYS_CLK_KHZ;
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WA1,
    ST_WA2,
    ST_DATA,
    ST_READ
  } tw_state_t;
endpackage : tw_pkg

// ==== tw_prog_timer.sv ====
module tw_prog_timer #(
  parameter int PROG_CYCLES = tw_pkg::PROG_CYCLES
) (
  // system
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // to core
  tw_link_if.timer tm
);
  localparam int TW = $clog2(PROG_CYCLES + 1);
  localparam logic [TW-1:0] LOAD = TW'(PROG_CYCLES);
  logic [TW-1:0] cnt_reg;
  logic busy_reg;

  // self-timed cycle, ends within the longest time
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else if (tm.prog_start && !busy_reg) begin
      cnt_reg <= LOAD;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - TW'(1);
      busy_reg <= (cnt_reg > TW'(1));
    end
  end

  assign tm.prog_busy = busy_reg;
endmodule : tw_prog_timer

// ==== tw_target_fe.sv ====
// Functional notes
// - data changes while clock high are Start or Stop, never data bits.
// - falling data with clock high is Start; new transfer decode begins.
// - rising data with clock high is Stop; device returns to standby.
// - eight-bit words, each acknowledged by pulling data low on ninth clock.
// - standby after reset, and after Stop once program cycle finished.
// - Start, nine clocks, Start, Stop leaves device ready for transfer.
// - device address upper nibble 1010 selects the main array.
// - bits 3..1 must match select pins; mismatch gives no ack, standby.
// - address word bit 0 one means read, zero means write.
// - upper nibble 1011 selects serial-number block, same pin compare.
// - serial block is read-only; zero direction only for pointer load.
// - first address byte: array bits 11..8, serial block tag 10.
// - second address byte: array bits 7..0, serial block offset 4..0.
// - program cycle starts at Stop ending a write, done within 5 ms.
// - during program cycle inputs ignored, device address not acknowledged.
// - write-protect high blocks all array writes, reads still allowed.
// - data output is open-drain: pull low or release only.
module tw_target_fe #(
  parameter int PROG_CYCLES = tw_pkg::PROG_CYCLES
) (
  // system
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // two-wire pins
  input wire logic i_scl_clk,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  // hard-wired straps
  input wire logic i_select_pin_hi,
  input wire logic i_select_pin_mid,
  input wire logic i_select_pin_lo,
  input wire logic i_write_protect,
  // status
  output logic o_standby,
  output logic o_prog_busy,
  output logic o_sn_sel,
  output logic o_sn_addr_ok,
  output logic o_read_op,
  output logic o_dev_ack,
  // write side
  output logic [tw_pkg::ADDR_W-1:0] o_addr_ptr,
  output logic [tw_pkg::WORD_W-1:0] o_wr_data,
  output logic o_wr_valid
);
  tw_link_if lk ();

  logic [tw_pkg::PIN_N-1:0] pin_raw;
  logic [tw_pkg::PIN_N-1:0] pin_meta_reg;
  logic [tw_pkg::PIN_N-1:0] pin_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_d_reg;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic [2:0] sel_s;
  logic bit_evt;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic word_done;
  logic ack_done;
  tw_pkg::tw_state_t state_reg;
  tw_pkg::tw_state_t state_next;
  logic [tw_pkg::CNT_W-1:0] cnt_reg;
  logic [tw_pkg::WORD_W-1:0] shift_reg;
  logic drive_reg;
  logic ack_now;
  logic dev_hit;
  logic sn_sel_reg;
  logic sn_ok_reg;
  logic read_reg;
  logic [tw_pkg::ADDR_W-1:0] ptr_reg;
  logic [tw_pkg::WORD_W-1:0] wr_data_reg;
  logic wr_valid_reg;
  logic wr_pend_reg;
  logic dev_ack_reg;
  logic prog_start;

  // serial clock domain bit capture
  tw_link_rx u_link_rx (
    .i_scl_clk(i_scl_clk),
    .i_srst(i_srst),
    .i_sda_i(i_sda_i),
    .lk(lk)
  );

  // self-timed program cycle
  tw_prog_timer #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog_timer (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .tm(lk)
  );

  function automatic logic is_serial_code(input logic [tw_pkg::WORD_W-1:0] w);
    is_serial_code = (w[tw_pkg::DEV_CODE_MSB:tw_pkg::DEV_CODE_LSB] == tw_pkg::DEV_CODE_SERIAL);
  endfunction : is_serial_code

  function automatic logic is_array_code(input logic [tw_pkg::WORD_W-1:0] w);
    is_array_code = (w[tw_pkg::DEV_CODE_MSB:tw_pkg::DEV_CODE_LSB] == tw_pkg::DEV_CODE_ARRAY);
  endfunction : is_array_code

  assign pin_raw = {i_scl_clk, i_sda_i, i_write_protect,
                    i_select_pin_hi, i_select_pin_mid, i_select_pin_lo};

  // two-stage synchronisers for all pins
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign scl_s = pin_sync_reg[tw_pkg::PIN_SCL];
  assign sda_s = pin_sync_reg[tw_pkg::PIN_SDA];
  assign wp_s = pin_sync_reg[tw_pkg::PIN_WP];
  assign sel_s = pin_sync_reg[tw_pkg::PIN_SEL_MSB:tw_pkg::PIN_SEL_LSB];

  // delayed copies for edge detection
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // bit toggle crossing from the link clock
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_d_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= lk.bit_tgl;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_d_reg <= tgl_sync_reg;
    end
  end

  assign bit_evt = tgl_sync_reg ^ tgl_d_reg;
  assign scl_fall = scl_d_reg && !scl_s;
  assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign word_done = scl_fall && (cnt_reg == tw_pkg::BIT_WORD_DONE);
  assign ack_done = scl_fall && (cnt_reg == tw_pkg::BIT_ACK_DONE);

  // bit counter and shifter, restarted by any Start or Stop
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_reg <= '0;
      shift_reg <= tw_pkg::WORD_RESET;
    end else if (start_cond || stop_cond) begin
      cnt_reg <= '0;
    end else if (ack_done) begin
      cnt_reg <= '0;
    end else if (bit_evt && cnt_reg < tw_pkg::BIT_ACK_DONE) begin
      cnt_reg <= cnt_reg + tw_pkg::CNT_W'(1);
      if (cnt_reg < tw_pkg::BIT_WORD_DONE) begin
        shift_reg <= {shift_reg[tw_pkg::WORD_W-2:0], lk.bit_val};
      end
    end
  end

  // device address compare
  assign dev_hit = (is_array_code(shift_reg) || is_serial_code(shift_reg))
                   && (shift_reg[tw_pkg::DEV_SEL_MSB:tw_pkg::DEV_SEL_LSB] == sel_s);

  // acknowledge decision for the word just completed
  always_comb begin
    ack_now = 1'b0;
    case (state_reg)
      tw_pkg::ST_DEV: begin
        ack_now = dev_hit && !lk.prog_busy;
      end
      tw_pkg::ST_WA1: begin
        ack_now = 1'b1;
      end
      tw_pkg::ST_WA2: begin
        ack_now = 1'b1;
      end
      tw_pkg::ST_DATA: begin
        ack_now = !sn_sel_reg;
      end
      default: begin
        ack_now = 1'b0;
      end
    endcase
  end

  // next state after a completed word
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tw_pkg::ST_IDLE: begin
        state_next = tw_pkg::ST_IDLE;
      end
      tw_pkg::ST_DEV: begin
        if (!ack_now) begin
          state_next = tw_pkg::ST_IDLE;
        end else if (shift_reg[tw_pkg::DEV_DIR_BIT]) begin
          state_next = tw_pkg::ST_READ;
        end else begin
          state_next = tw_pkg::ST_WA1;
        end
      end
      tw_pkg::ST_WA1: begin
        state_next = tw_pkg::ST_WA2;
      end
      tw_pkg::ST_WA2: begin
        state_next = tw_pkg::ST_DATA;
      end
      tw_pkg::ST_DATA: begin
        state_next = sn_sel_reg ? tw_pkg::ST_IDLE : tw_pkg::ST_DATA;
      end
      tw_pkg::ST_READ: begin
        state_next = tw_pkg::ST_READ;
      end
      default: begin
        state_next = tw_pkg::ST_IDLE;
      end
    endcase
  end

  // protocol state
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_reg <= tw_pkg::ST_IDLE;
    end else if (start_cond) begin
      state_reg <= tw_pkg::ST_DEV;
    end else if (stop_cond) begin
      state_reg <= tw_pkg::ST_IDLE;
    end else if (word_done) begin
      state_reg <= state_next;
    end
  end

  // open-drain acknowledge on the ninth clock
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      drive_reg <= 1'b0;
    end else if (start_cond || stop_cond || ack_done) begin
      drive_reg <= 1'b0;
    end else if (word_done) begin
      drive_reg <= ack_now;
    end
  end

  // device address acknowledge pulse
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dev_ack_reg <= 1'b0;
    end else begin
      dev_ack_reg <= word_done && (state_reg == tw_pkg::ST_DEV) && ack_now;
    end
  end

  // access area, direction and address pointer
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      sn_sel_reg <= 1'b0;
      sn_ok_reg <= 1'b0;
      read_reg <= 1'b0;
      ptr_reg <= tw_pkg::PTR_RESET;
    end else if (word_done && ack_now) begin
      case (state_reg)
        tw_pkg::ST_DEV: begin
          sn_sel_reg <= is_serial_code(shift_reg);
          read_reg <= shift_reg[tw_pkg::DEV_DIR_BIT];
        end
        tw_pkg::ST_WA1: begin
          if (sn_sel_reg) begin
            sn_ok_reg <= (shift_reg[tw_pkg::SN_TAG_MSB:tw_pkg::SN_TAG_LSB] == tw_pkg::SN_TAG);
            ptr_reg[tw_pkg::ADDR_W-1:tw_pkg::WORD_W] <= '0;
          end else begin
            ptr_reg[tw_pkg::ADDR_W-1:tw_pkg::WORD_W] <= shift_reg[tw_pkg::WA1_HI_MSB:tw_pkg::WA1_HI_LSB];
          end
        end
        tw_pkg::ST_WA2: begin
          if (sn_sel_reg) begin
            ptr_reg[tw_pkg::WORD_W-1:0] <= {3'h0, shift_reg[tw_pkg::SN_OFS_MSB:0]};
          end else begin
            ptr_reg[tw_pkg::WORD_W-1:0] <= shift_reg[tw_pkg::WA2_LO_MSB:0];
          end
        end
        default: begin
          ptr_reg <= ptr_reg;
        end
      endcase
    end
  end

  // accepted write data, blocked by write protect
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_data_reg <= tw_pkg::WORD_RESET;
      wr_valid_reg <= 1'b0;
    end else begin
      wr_valid_reg <= 1'b0;
      if (word_done && state_reg == tw_pkg::ST_DATA && !sn_sel_reg && !wp_s) begin
        wr_data_reg <= shift_reg;
        wr_valid_reg <= 1'b1;
      end
    end
  end

  // pending write awaiting its Stop, set wins over clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wr_pend_reg <= 1'b0;
    end else if (word_done && state_reg == tw_pkg::ST_DATA && !sn_sel_reg && !wp_s) begin
      wr_pend_reg <= 1'b1;
    end else if (start_cond || stop_cond) begin
      wr_pend_reg <= 1'b0;
    end
  end

  // program cycle launched by Stop ending a write
  assign prog_start = stop_cond && (state_reg == tw_pkg::ST_DATA) && wr_pend_reg
                      && !wp_s && !sn_sel_reg && !lk.prog_busy;
  assign lk.prog_start = prog_start;

  // outputs
  assign o_sda_o = 1'b0;
  assign o_sda_oe = !drive_reg;
  assign o_standby = (state_reg == tw_pkg::ST_IDLE) && !lk.prog_busy;
  assign o_prog_busy = lk.prog_busy;
  assign o_sn_sel = sn_sel_reg;
  assign o_sn_addr_ok = sn_ok_reg;
  assign o_read_op = read_reg;
  assign o_dev_ack = dev_ack_reg;
  assign o_addr_ptr = ptr_reg;
  assign o_wr_data = wr_data_reg;
  assign o_wr_valid = wr_valid_reg;
endmodule : tw_target_fe

// ==== tw_target_fe_bench.sv ====
module tw_target_fe_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC = 2000;
  logic i_sys_clk = 1'b0, i_srst = 1'b1, i_write_protect = 1'b0;
  logic i_select_pin_hi = 1'b0, i_select_pin_mid = 1'b1, i_select_pin_lo = 1'b1;
  logic i_scl_clk, i_sda_i, o_sda_o, o_sda_oe, o_standby, o_prog_busy, o_sn_sel;
  logic o_sn_addr_ok, o_read_op, o_dev_ack, o_wr_valid, sda_drv, ack;
  logic got_ack = 1'b0, got_wr = 1'b0;
  logic [tw_pkg::ADDR_W-1:0] o_addr_ptr;
  logic [tw_pkg::WORD_W-1:0] o_wr_data;
  int num_errors = 0, tests_run = 0, cyc = 0;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
  // open-drain wire with pull-up
  assign i_sda_i = sda_drv & (o_sda_oe | o_sda_o);
  initial forever #4 i_sys_clk = ~i_sys_clk;
  tw_target_fe #(.PROG_CYCLES(PC)) dut_u (.i_sys_clk, .i_srst, .i_scl_clk, .i_sda_i,
    .o_sda_o, .o_sda_oe, .i_select_pin_hi, .i_select_pin_mid, .i_select_pin_lo,
    .i_write_protect, .o_standby, .o_prog_busy, .o_sn_sel, .o_sn_addr_ok, .o_read_op,
    .o_dev_ack, .o_addr_ptr, .o_wr_data, .o_wr_valid);
  tw_ctrl_model ctrl_u (.i_sda_wire(i_sda_i), .o_scl(i_scl_clk), .o_sda_drv(sda_drv));
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  always @(posedge i_sys_clk) begin
    cyc++;
    if (o_dev_ack === 1'b1) got_ack <= 1'b1;
    if (o_wr_valid === 1'b1) got_wr <= 1'b1;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic xfer(input logic [7:0] w, input logic e, input string n);
    ctrl_u.byte_c(w, ack);
    `CHK(n, e, ack)
    #40;
  endtask : xfer
  task automatic wait_idle();
    for (int i = 0; i < 3000 && o_prog_busy !== 1'b0; i++) @(posedge i_sys_clk);
    #1;
  endtask : wait_idle
  task automatic t_write();
    got_ack = 1'b0;
    got_wr = 1'b0;
    ctrl_u.start_c();
    xfer(8'ha6, 1'b1, "dev");
    `CHK("dack", 1'b1, got_ack)
    `CHK("rdop", 1'b0, o_read_op)
    xfer(8'hf5, 1'b1, "wa1");
    xfer(8'ha3, 1'b1, "wa2");
    `CHK("ptr", 12'h5a3, o_addr_ptr)
    xfer(8'h3c, 1'b1, "dat");
    `CHK("wdat", 8'h3c, o_wr_data)
    `CHK("wv", 1'b1, got_wr)
    ctrl_u.stop_c();
    `CHK("busy", 1'b1, o_prog_busy)
    `CHK("sby", 1'b0, o_standby)
    ctrl_u.start_c();
    xfer(8'ha6, 1'b0, "poll");
    ctrl_u.stop_c();
    wait_idle();
    `CHK("sby2", 1'b1, o_standby)
    ctrl_u.start_c();
    xfer(8'ha6, 1'b1, "poll2");
    ctrl_u.stop_c();
    $display("done write");
  endtask : t_write
  task automatic t_recover();
    ctrl_u.start_c();
    xfer(8'ha4, 1'b0, "mis");
    `CHK("sbym", 1'b1, o_standby)
    ctrl_u.start_c();
    ctrl_u.clk9();
    ctrl_u.start_c();
    ctrl_u.stop_c();
    ctrl_u.start_c();
    xfer(8'ha7, 1'b1, "rd");
    `CHK("rdop1", 1'b1, o_read_op)
    ctrl_u.stop_c();
    `CHK("sbyr", 1'b1, o_standby)
    $display("done recover");
  endtask : t_recover
  task automatic t_serial();
    got_wr = 1'b0;
    ctrl_u.start_c();
    xfer(8'hb6, 1'b1, "sdev");
    `CHK("snsel", 1'b1, o_sn_sel)
    xfer(8'hf8, 1'b1, "sa1");
    `CHK("snok", 1'b1, o_sn_addr_ok)
    xfer(8'he4, 1'b1, "sa2");
    `CHK("snptr", 12'h004, o_addr_ptr)
    xfer(8'h55, 1'b0, "sdat");
    ctrl_u.stop_c();
    `CHK("snwv", 1'b0, got_wr)
    `CHK("snbusy", 1'b0, o_prog_busy)
    ctrl_u.start_c();
    xfer(8'hb7, 1'b1, "srd");
    `CHK("snrd", 1'b1, o_read_op)
    `CHK("snsel2", 1'b1, o_sn_sel)
    ctrl_u.start_c();
    xfer(8'hb6, 1'b1, "sdev2");
    xfer(8'h04, 1'b1, "sbad");
    `CHK("snbad", 1'b0, o_sn_addr_ok)
    ctrl_u.stop_c();
    $display("done serial");
  endtask : t_serial
  task automatic t_wp();
    @(posedge i_sys_clk) i_write_protect <= 1'b1;
    got_wr = 1'b0;
    ctrl_u.start_c();
    xfer(8'ha6, 1'b1, "wdev");
    xfer(8'h01, 1'b1, "wwa1");
    xfer(8'h02, 1'b1, "wwa2");
    xfer(8'h77, 1'b1, "wdat");
    ctrl_u.stop_c();
    `CHK("wpwv", 1'b0, got_wr)
    `CHK("wpbusy", 1'b0, o_prog_busy)
    `CHK("wpdat", 8'h3c, o_wr_data)
    @(posedge i_sys_clk) i_write_protect <= 1'b0;
    $display("done protect");
  endtask : t_wp
  task automatic t_rst();
    ctrl_u.start_c();
    xfer(8'ha6, 1'b1, "rdev");
    xfer(8'h0f, 1'b1, "rwa1");
    xfer(8'hff, 1'b1, "rwa2");
    xfer(8'h11, 1'b1, "rdat");
    ctrl_u.stop_c();
    `CHK("rsbusy", 1'b1, o_prog_busy)
    @(posedge i_sys_clk) i_srst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    `CHK("rsbusy2", 1'b0, o_prog_busy)
    `CHK("rssby", 1'b1, o_standby)
    `CHK("rsptr", 12'h000, o_addr_ptr)
    `CHK("rswd", 8'h00, o_wr_data)
    ctrl_u.start_c();
    xfer(8'ha7, 1'b1, "rspoll");
    ctrl_u.stop_c();
    $display("done mid reset");
  endtask : t_rst
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    `CHK("roe", 1'b1, o_sda_oe)
    `CHK("rsby", 1'b1, o_standby)
    `CHK("rbusy", 1'b0, o_prog_busy)
    $display("done reset");
    t_write();
    t_recover();
    t_serial();
    t_wp();
    t_rst();
    give_verdict();
  end
endmodule : tw_target_fe_bench
bind tw_target_fe tw_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.i_sys_clk, .i_srst,
  .i_scl_clk, .i_write_protect, .o_sda_o, .o_sda_oe, .o_standby, .o_prog_busy, .o_sn_sel,
  .o_read_op, .o_dev_ack, .o_wr_valid);
